// ===== hdl/qps_pkg.sv
// Package for the four-rail power sequencer: states, timing and carrier types
package qps_pkg;

  localparam int unsigned CLK_FREQ_HZ  = 125_000_000;
  localparam int unsigned LONG_DLY_MS  = 190;
  localparam int unsigned SHORT_DLY_US = 30;
  localparam int unsigned LONG_DLY_CYC  = (CLK_FREQ_HZ / 1000) * LONG_DLY_MS;
  localparam int unsigned SHORT_DLY_CYC = (CLK_FREQ_HZ / 1000000) * SHORT_DLY_US;
  localparam int unsigned TMR_W = 25;

  typedef enum logic [2:0] {
    QPS_RESET,
    QPS_EN1_ON,
    QPS_EN12_ON,
    QPS_EN123_ON,
    QPS_PWR_GOOD
  } qps_state_t;

  typedef struct packed {
    logic rail_in_4;
    logic rail_in_3;
    logic rail_in_2;
    logic rail_in_1;
  } qps_rails_t;

  typedef struct packed {
    logic supplies_ok_out;
    logic reg_enable_3;
    logic reg_enable_2;
    logic reg_enable_1;
  } qps_outs_t;

  localparam qps_outs_t OUTS_RST = 4'h0;

endpackage

// ===== hdl/qps_sequencer.sv
// Four-rail power sequencer core: enable stepping, qualification and fault monitor
// Notes on behaviour
// - After reset all enables and power good stay low until rail 1 qualifies.
// - Reset state: first enable after rail 1 high for 190 ms.
// - Enable 2 after rails 1 and 2 both high for 30 us.
// - Enable 3 after rails 1 and 3 both high for 30 us.
// - Power good after all rails high for 190 ms with all enables on.
// - After power good, enables ignore individual rails; only faults act.
// - Monitoring: rail 1 low 30 us drops everything, back to reset.
// - Monitoring: rail 2/3/4 low 30 us drops power good only.
// - Outputs active high: asserted is high, deasserted driven low.
module qps_sequencer
  import qps_pkg::*;
#(
  parameter int unsigned LONG_CYC  = LONG_DLY_CYC,
  parameter int unsigned SHORT_CYC = SHORT_DLY_CYC
)
(
  input  wire logic       ref_clk,   // 125 MHz clock
  input  wire logic       sys_rst,   // Async reset, active high
  input  wire qps_rails_t rails,     // Digitized comparator results
  output qps_outs_t       outs       // Enables and power good
);

  qps_state_t       state_r;
  qps_state_t       state_nxt;
  logic [TMR_W-1:0] qual_tmr_r;
  logic [TMR_W-1:0] fault_tmr_r;
  logic             qual_cond;
  logic             fault_cond;
  logic             rail1_fault;
  logic             qual_done;
  logic             fault_done;
  logic [TMR_W-1:0] aux_tmr_r;
  logic             aux_cond;
  logic             aux_done;
  logic [TMR_W-1:0] qual_lim;
  logic             all_high;

  assign all_high = &rails;

  // Condition that must hold uninterrupted to advance
  always_comb
  begin
    qual_cond = 1'b0;
    qual_lim  = TMR_W'(SHORT_CYC);
    unique case (state_r)
      QPS_RESET:
      begin
        qual_cond = rails.rail_in_1;
        qual_lim  = TMR_W'(LONG_CYC);
      end
      QPS_EN1_ON:   qual_cond = rails.rail_in_1 & rails.rail_in_2;
      QPS_EN12_ON:  qual_cond = rails.rail_in_1 & rails.rail_in_3;
      QPS_EN123_ON:
      begin
        qual_cond = all_high;
        qual_lim  = TMR_W'(LONG_CYC);
      end
      QPS_PWR_GOOD: qual_cond = 1'b0;
    endcase
  end

  // Separate fault timers, so a dip on rail 1 is never finished by a dip on rails 2-4
  // Rail 1 is watched in every state but reset; rails 2-4 only while monitoring
  assign rail1_fault = ~rails.rail_in_1;
  assign fault_cond  = (state_r != QPS_RESET) & rail1_fault;
  assign aux_cond    = (state_r == QPS_PWR_GOOD)
                     & ~(rails.rail_in_2 & rails.rail_in_3 & rails.rail_in_4);
  assign qual_done   = qual_cond & (qual_tmr_r == qual_lim - TMR_W'(1));
  assign fault_done  = fault_cond & (fault_tmr_r == TMR_W'(SHORT_CYC) - TMR_W'(1));
  assign aux_done    = aux_cond & (aux_tmr_r == TMR_W'(SHORT_CYC) - TMR_W'(1));

  always_comb
  begin
    state_nxt = state_r;
    // Rail 1 outranks rails 2-4 when both time out in one cycle
    if (fault_done)
      state_nxt = QPS_RESET;
    else if (aux_done)
      state_nxt = QPS_EN123_ON;
    else if (qual_done)
    begin
      unique case (state_r)
        QPS_RESET:    state_nxt = QPS_EN1_ON;
        QPS_EN1_ON:   state_nxt = QPS_EN12_ON;
        QPS_EN12_ON:  state_nxt = QPS_EN123_ON;
        QPS_EN123_ON: state_nxt = QPS_PWR_GOOD;
        QPS_PWR_GOOD: state_nxt = QPS_PWR_GOOD;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= QPS_RESET;
    else
      state_r <= state_nxt;
  end

  // Timers clear on any break or state change
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      qual_tmr_r <= '0;
    else if (!qual_cond || state_nxt != state_r)
      qual_tmr_r <= '0;
    else
      qual_tmr_r <= qual_tmr_r + TMR_W'(1);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_tmr_r <= '0;
    else if (!fault_cond || state_nxt != state_r)
      fault_tmr_r <= '0;
    else
      fault_tmr_r <= fault_tmr_r + TMR_W'(1);
  end

  // Rails 2-4 share one timer: any of them low keeps it running
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      aux_tmr_r <= '0;
    else if (!aux_cond || state_nxt != state_r)
      aux_tmr_r <= '0;
    else
      aux_tmr_r <= aux_tmr_r + TMR_W'(1);
  end

  // Outputs registered from next state so they follow the state exactly
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      outs <= OUTS_RST;
    else
    begin
      outs.reg_enable_1    <= state_nxt != QPS_RESET;
      outs.reg_enable_2    <= state_nxt inside {QPS_EN12_ON, QPS_EN123_ON, QPS_PWR_GOOD};
      outs.reg_enable_3    <= state_nxt inside {QPS_EN123_ON, QPS_PWR_GOOD};
      outs.supplies_ok_out <= state_nxt == QPS_PWR_GOOD;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  reset_quiet_a: assert property (state_r == QPS_RESET |-> outs == OUTS_RST)
    else $error("outputs active in reset state");
  en1_qual_a: assert property ($rose(outs.reg_enable_1) |->
      $past(qual_tmr_r) == TMR_W'(LONG_CYC - 1) && $past(rails.rail_in_1))
    else $error("enable 1 rose without 190 ms qualification");
  en2_qual_a: assert property ($rose(outs.reg_enable_2) |->
      $past(rails.rail_in_2) && $past(qual_tmr_r) == TMR_W'(SHORT_CYC - 1))
    else $error("enable 2 rose without 30 us qualification");
  en3_qual_a: assert property ($rose(outs.reg_enable_3) |->
      $past(rails.rail_in_3) && outs.reg_enable_2)
    else $error("enable 3 rose out of order");
  pg_and_a: assert property (outs.supplies_ok_out |->
      outs.reg_enable_1 && outs.reg_enable_2 && outs.reg_enable_3)
    else $error("power good without all enables");
  mon_hold_a: assert property (state_r == QPS_PWR_GOOD && rails.rail_in_1
      |=> outs.reg_enable_1 && outs.reg_enable_2 && outs.reg_enable_3)
    else $error("enable dropped in monitoring without rail 1 fault");
  rail1_drop_a: assert property (state_r == QPS_PWR_GOOD && fault_done && rail1_fault
      |=> outs == OUTS_RST && state_r == QPS_RESET)
    else $error("rail 1 fault did not clear outputs");
  rail_other_a: assert property (state_r == QPS_PWR_GOOD && aux_done && !fault_done
      |=> !outs.supplies_ok_out && outs.reg_enable_3 && state_r == QPS_EN123_ON)
    else $error("secondary rail fault mishandled");
  tmr_restart_a: assert property (!qual_cond |=> qual_tmr_r == '0)
    else $error("qualification timer kept counting");
  seq_fault_a: assert property (state_r inside {QPS_EN1_ON, QPS_EN12_ON} && fault_done
      |=> state_r == QPS_RESET && !outs.reg_enable_1)
    else $error("sequencing rail 1 fault not handled");

  pg_qual_a: assert property ($rose(outs.supplies_ok_out) |->
      $past(qual_tmr_r) == TMR_W'(LONG_CYC - 1) && $past(all_high))
    else $error("power good rose without 190 ms qualification");
  en2_order_a: assert property (outs.reg_enable_2 |->
      outs.reg_enable_1)
    else $error("enable 2 on without enable 1");
  en3_order_a: assert property (outs.reg_enable_3 |->
      outs.reg_enable_1 && outs.reg_enable_2)
    else $error("enable 3 on without earlier enables");
  pg_state_a: assert property (outs.supplies_ok_out ==
      (state_r == QPS_PWR_GOOD))
    else $error("power good out of step with monitoring mode");
  en123_fault_a: assert property (state_r == QPS_EN123_ON && fault_done
      |=> state_r == QPS_RESET && outs == OUTS_RST)
    else $error("rail 1 fault before power good not handled");
  flt_restart_a: assert property (!fault_cond |=> fault_tmr_r == '0)
    else $error("rail 1 fault timer kept counting");
  aux_restart_a: assert property (!aux_cond |=> aux_tmr_r == '0)
    else $error("secondary fault timer kept counting");
  qual_bound_a: assert property (qual_tmr_r < qual_lim)
    else $error("qualification timer ran past its limit");

  pwr_up_c:   cover property (state_r == QPS_EN123_ON ##1 state_r == QPS_PWR_GOOD);
  main_flt_c: cover property (state_r == QPS_PWR_GOOD ##1 state_r == QPS_RESET);
  sec_flt_c:  cover property (state_r == QPS_PWR_GOOD ##1 state_r == QPS_EN123_ON);
  seq_flt_c:  cover property (state_r == QPS_EN1_ON ##1 state_r == QPS_RESET);
  dip_c:      cover property (aux_cond ##1 !aux_cond && state_r == QPS_PWR_GOOD);

endmodule

// ===== tb/qps_reg_model.sv
// Regulator and main supply model feeding the sequencer rails
module qps_reg_model
  import qps_pkg::*;
(
  input  wire logic       ref_clk,  // Clock
  input  wire qps_outs_t  outs,     // Enables from sequencer
  input  wire logic [3:0] kill,     // Forces a rail low
  input  wire logic       main_on,  // Main supply present
  output qps_rails_t      rails     // Comparator results
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_r;
  // Each regulator output is up one cycle after its enable
  always_ff @(posedge ref_clk)
    up_r <= {outs.reg_enable_3, outs.reg_enable_2, outs.reg_enable_1};
  assign rails = {up_r, main_on} & ~kill;
endmodule

// ===== tb/quad_rail_power_sequencer_tb_top.sv
// Self-checking bench for the four-rail power sequencer
module quad_rail_power_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qps_pkg::*;
  localparam int unsigned LC = 20;
  localparam int unsigned SC = 4;
  logic       ref_clk   = 1'b0;
  logic       sys_rst   = 1'b1;
  logic       main_on   = 1'b0;
  logic [3:0] kill      = 4'h0;
  qps_rails_t rails;
  qps_outs_t  outs;
  int         failures  = 0;
  int         tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  qps_reg_model i_model (.ref_clk(ref_clk), .outs(outs), .kill(kill), .main_on(main_on),
                         .rails(rails));
  qps_sequencer #(.LONG_CYC(LC), .SHORT_CYC(SC)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
                                                       .rails(rails), .outs(outs));
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wait_outs(string what, logic [3:0] exp, int max);
    for (int i = 0; i < max && outs !== exp; i++) @(negedge ref_clk);
    check(what, outs, exp);
  endtask
  task automatic t_power_up();
    check("reset outs", outs, 4'h0);
    main_on = 1'b1;
    idle(LC - 1);
    check("en1 early", outs, 4'h0);
    idle(1);
    check("en1 on time", outs, 4'h1);
    wait_outs("en2", 4'h3, SC + 4);
    wait_outs("en3", 4'h7, SC + 4);
    // Rail 4 follows enable 3 one cycle late
    idle(LC);
    check("pg early", outs, 4'h7);
    idle(1);
    check("pg on time", outs, 4'hf);
    $display("test power_up done");
  endtask
  task automatic t_faults();
    kill = 4'h1;
    idle(SC - 1);
    kill = 4'h2;
    idle(SC - 1);
    kill = 4'h0;
    idle(2);
    check("short dips", outs, 4'hf);
    kill = 4'h4;
    idle(SC);
    check("rail3 fault", outs, 4'h7);
    kill = 4'h0;
    wait_outs("pg again", 4'hf, LC + 4);
    kill = 4'h1;
    idle(SC);
    check("rail1 fault", outs, 4'h0);
    kill = 4'h0;
    wait_outs("en1 again", 4'h1, LC + 4);
    kill = 4'h1;
    idle(SC);
    check("seq fault", outs, 4'h0);
    kill = 4'h0;
    $display("test faults done");
  endtask
  task automatic end_of_test();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole run is a little over a hundred cycles
  initial
  begin
    #16000;
    failures++;
    end_of_test();
  end
  initial
  begin
    idle(3);
    sys_rst = 1'b0;
    idle(1);
    t_power_up();
    t_faults();
    end_of_test();
  end
endmodule
